// *** hdl/sync_serial_output.sv ***
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;
  always_comb begin
    full        = (wr_ptr[PW] != rd_ptr[PW]) &&
                  (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    empty       = (wr_ptr == rd_ptr);
    in_ready_o  = !full;
    out_valid_o = !empty;
    out_data_o  = mem[rd_ptr[PW-1:0]];
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end
endmodule

// Operation
// - when enabled, three segment pins carry serial clock, data, frame.
// - enabled with display driver on, the pins stay with the display segments.
// - the serial clock runs at 5 MHz with speed bit 0, 10 MHz with 1.
// - gate bit low gives a free clock, high holds it low when idle.
// - frame pulse once per block, or every 8, 16 or 32 bits by format.
// - frame pulse is active high with polarity 0, active low with 1.
// - fourth pin is the ready output only with ready and output enabled.
// - ready is active high with polarity 0, active low with 1.
// - words from begin to end address are sent, end above begin.
module sync_serial_output #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // register port
  input  wire logic [sso_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [sso_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                      reg_write_i,
  input  wire logic                      reg_read_i,
  output logic [sso_pkg::DATA_W-1:0]     reg_rdata_o,
  // engine pass and data memory
  input  wire logic                      pass_start_i,
  output logic                           mem_rd_o,
  output logic [sso_pkg::MEM_AW-1:0]     mem_addr_o,
  input  wire logic [sso_pkg::WORD_BITS-1:0] mem_data_i,
  // display side
  input  wire logic                      display_driver_enable_i,
  input  wire logic [3:0]                display_seg_i,
  // shared pins
  output logic                           segment_pin_a_o,
  output logic                           segment_pin_b_o,
  output logic                           segment_pin_c_o,
  output logic                           segment_pin_d_o
);
  import sso_pkg::*;
  logic [7:0]           ctrl, begin_addr, end_addr;
  logic [7:0]           next_ctrl, next_begin_addr, next_end_addr, next_rdata;
  fetch_state_e         fstate, next_fstate;
  logic [7:0]           fetch_addr, next_fetch_addr;
  logic                 next_mem_rd, mem_pending, first_word, next_first_word;
  logic [DIV_W-1:0]     div_cnt, next_div_cnt;
  logic                 sclk, next_sclk, shifting, next_shifting;
  logic [WORD_BITS-1:0] shreg, next_shreg;
  logic [POS_W-1:0]     bitpos, next_bitpos;
  logic                 frame_act, next_frame_act, pop_word;
  logic [3:0]           next_pins;
  logic                 sso_on, tick, drive_ev;
  logic [1:0]           fmt;
  logic                 fifo_in_ready, fifo_out_valid;
  logic [WORD_BITS-1:0] fifo_out_data;
  function automatic logic frame_at(input logic [1:0] f,
                                    input logic [POS_W-1:0] pos,
                                    input logic first);
    case (f)
      FMT_BLOCK: frame_at = first && (pos == '0);
      FMT_8:     frame_at = (pos[2:0] == 3'h0);
      FMT_16:    frame_at = (pos[3:0] == 4'h0);
      FMT_32:    frame_at = (pos == '0);
      default:   frame_at = 1'b0;
    endcase
  endfunction
  assign fmt    = ctrl[FMT_HI:FMT_LO];
  assign sso_on = ctrl[EN_BIT] && !display_driver_enable_i;
  always_comb begin
    next_ctrl       = ctrl;
    next_begin_addr = begin_addr;
    next_end_addr   = end_addr;
    next_rdata      = 8'h00;
    if (reg_write_i) begin
      case (reg_addr_i)
        CTRL_ADDR:  next_ctrl = reg_wdata_i;
        BEGIN_ADDR: next_begin_addr = reg_wdata_i;
        END_ADDR:   next_end_addr = reg_wdata_i;
        default:    next_ctrl = ctrl;
      endcase
    end
    if (reg_read_i) begin
      case (reg_addr_i)
        CTRL_ADDR:   next_rdata = ctrl;
        BEGIN_ADDR:  next_rdata = begin_addr;
        END_ADDR:    next_rdata = end_addr;
        STATUS_ADDR: begin
          next_rdata[ST_SHIFT_BIT] = shifting;
          next_rdata[ST_BLOCK_BIT] = (fstate != FS_IDLE);
        end
        default:     next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl        <= CTRL_RESET;
      begin_addr  <= BEGIN_RESET;
      end_addr    <= END_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      ctrl        <= next_ctrl;
      begin_addr  <= next_begin_addr;
      end_addr    <= next_end_addr;
      reg_rdata_o <= next_rdata;
    end
  end
  always_comb begin
    next_fstate     = fstate;
    next_fetch_addr = fetch_addr;
    next_mem_rd     = 1'b0;
    next_first_word = first_word;
    if (pop_word) begin
      next_first_word = 1'b0;
    end
    case (fstate)
      FS_IDLE: begin
        if (pass_start_i && sso_on) begin
          next_fstate     = FS_FETCH;
          next_fetch_addr = begin_addr;
          next_first_word = 1'b1;
        end
      end
      FS_FETCH: begin
        if (!mem_rd_o && !mem_pending && fifo_in_ready) begin
          next_mem_rd = 1'b1;
          if (fetch_addr == end_addr) begin
            next_fstate = FS_SEND;
          end else begin
            next_fetch_addr = fetch_addr + 8'h01;
          end
        end
      end
      FS_SEND: begin
        if (!mem_rd_o && !mem_pending && !fifo_out_valid && !shifting) begin
          next_fstate = FS_IDLE;
        end
      end
      default: next_fstate = FS_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fstate      <= FS_IDLE;
      fetch_addr  <= 8'h00;
      mem_rd_o    <= 1'b0;
      mem_addr_o  <= 8'h00;
      mem_pending <= 1'b0;
      first_word  <= 1'b0;
    end else begin
      fstate      <= next_fstate;
      fetch_addr  <= next_fetch_addr;
      mem_rd_o    <= next_mem_rd;
      mem_addr_o  <= fetch_addr;
      mem_pending <= mem_rd_o;
      first_word  <= next_first_word;
    end
  end
  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (mem_pending),
    .in_data_i   (mem_data_i),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (pop_word)
  );
  always_comb begin
    tick         = (div_cnt == '0);
    next_div_cnt = div_cnt - 1'b1;
    if (tick) begin
      next_div_cnt = ctrl[FAST_BIT] ? DIV_W'(FAST_HALF - 1)
                                    : DIV_W'(SLOW_HALF - 1);
    end
    drive_ev  = tick && (sclk || (ctrl[GATE_BIT] && !shifting));
    next_sclk = sclk;
    if (tick) begin
      next_sclk = sclk ? 1'b0 : (shifting || !ctrl[GATE_BIT]);
    end
    next_shifting  = shifting;
    next_shreg     = shreg;
    next_bitpos    = bitpos;
    next_frame_act = frame_act;
    pop_word       = 1'b0;
    if (drive_ev) begin
      if (shifting && bitpos != POS_W'(WORD_BITS - 1)) begin
        next_shreg     = {shreg[WORD_BITS-2:0], 1'b0};
        next_bitpos    = bitpos + 1'b1;
        next_frame_act = frame_at(fmt, next_bitpos, 1'b0);
      end else if (fifo_out_valid) begin
        pop_word       = 1'b1;
        next_shifting  = 1'b1;
        next_shreg     = fifo_out_data;
        next_bitpos    = '0;
        next_frame_act = frame_at(fmt, '0, first_word);
      end else begin
        next_shifting  = 1'b0;
        next_frame_act = 1'b0;
      end
    end
    next_pins = display_seg_i;
    if (sso_on) begin
      next_pins[0] = sclk;
      next_pins[1] = shreg[WORD_BITS-1];
      next_pins[2] = frame_act ^ ctrl[FPOL_BIT];
      if (ctrl[RDYEN_BIT]) begin
        next_pins[3] = shifting ^ ctrl[RDYPOL_BIT];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt         <= '0;
      sclk            <= 1'b0;
      shifting        <= 1'b0;
      shreg           <= '0;
      bitpos          <= '0;
      frame_act       <= 1'b0;
      segment_pin_a_o <= 1'b0;
      segment_pin_b_o <= 1'b0;
      segment_pin_c_o <= 1'b0;
      segment_pin_d_o <= 1'b0;
    end else begin
      div_cnt         <= next_div_cnt;
      sclk            <= next_sclk;
      shifting        <= next_shifting;
      shreg           <= next_shreg;
      bitpos          <= next_bitpos;
      frame_act       <= next_frame_act;
      segment_pin_a_o <= next_pins[0];
      segment_pin_b_o <= next_pins[1];
      segment_pin_c_o <= next_pins[2];
      segment_pin_d_o <= next_pins[3];
    end
  end
  logic [DIV_W-1:0] hi_len;
  logic [DIV_W-1:0] stable_len;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hi_len     <= '0;
      stable_len <= '0;
    end else begin
      hi_len     <= sclk ? hi_len + 1'b1 : '0;
      stable_len <= (next_sclk != sclk || ctrl[GATE_BIT]) ? '0
                                                          : stable_len + 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_clock_pin_route: assert property (
    $past(sso_on) |-> segment_pin_a_o == $past(sclk) &&
                      segment_pin_b_o == $past(shreg[WORD_BITS-1]))
    else $error("serial pins not routed while enabled");
  a_display_override: assert property (
    $past(ctrl[EN_BIT] && !display_driver_enable_i) |->
      segment_pin_a_o == $past(sclk))
    else $error("display pins not overridden");
  a_display_kept: assert property (
    $past(!sso_on && rst_n_i) |-> segment_pin_c_o == $past(display_seg_i[2]))
    else $error("display pin lost while disabled");
  a_clock_half_len: assert property (
    $fell(sclk) && $past(ctrl[FAST_BIT], 30) == ctrl[FAST_BIT] |->
      hi_len == (ctrl[FAST_BIT] ? DIV_W'(FAST_HALF) : DIV_W'(SLOW_HALF)))
    else $error("serial clock high time wrong");
  a_gate_holds_low: assert property (
    ctrl[GATE_BIT] && !shifting |=> !$rose(sclk))
    else $error("gated clock rose while idle");
  a_clock_free_run: assert property (
    !ctrl[GATE_BIT] |-> stable_len < DIV_W'(SLOW_HALF))
    else $error("free clock stopped");
  a_frame_place: assert property (
    $rose(frame_act) |-> (fmt == FMT_8 && bitpos[2:0] == 3'h0) ||
      (fmt == FMT_16 && bitpos[3:0] == 4'h0) || bitpos == '0)
    else $error("frame pulse misplaced");
  a_frame_polarity: assert property (
    $past(sso_on) |-> segment_pin_c_o == ($past(frame_act) ^
                                          $past(ctrl[FPOL_BIT])))
    else $error("frame polarity wrong");
  a_ready_route: assert property (
    $past((!ctrl[RDYEN_BIT] || !sso_on) && rst_n_i) |->
      segment_pin_d_o == $past(display_seg_i[3]))
    else $error("ready pin taken without enable");
  a_ready_level: assert property (
    $past(sso_on && ctrl[RDYEN_BIT]) |->
      segment_pin_d_o == ($past(shifting) ^ $past(ctrl[RDYPOL_BIT])))
    else $error("ready level wrong");
  a_fetch_range: assert property (
    mem_rd_o && $stable(begin_addr) && $stable(end_addr) |->
      mem_addr_o >= begin_addr && mem_addr_o <= end_addr)
    else $error("fetch outside block");
  a_data_on_fall: assert property (
    $changed(shreg[WORD_BITS-1]) && $past(shifting) |-> !sclk)
    else $error("data changed with clock high");
  c_block_sent: cover property (
    $rose(shifting) ##[1:1000] $fell(shifting));
  c_fast_gated: cover property (
    ctrl[FAST_BIT] && ctrl[GATE_BIT] && $rose(sclk));
  c_frame_byte: cover property (fmt == FMT_8 && $rose(frame_act));
  c_fifo_full: cover property (!fifo_in_ready);
endmodule

// *** hdl/sso_pkg.sv ***
package sso_pkg;
  // register map
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 8;
  localparam logic [15:0] CTRL_ADDR   = 16'h2070;
  localparam logic [15:0] BEGIN_ADDR  = 16'h2071;
  localparam logic [15:0] END_ADDR    = 16'h2072;
  localparam logic [15:0] STATUS_ADDR = 16'h2073;
  // control field positions
  localparam int EN_BIT     = 7;
  localparam int FAST_BIT   = 6;
  localparam int GATE_BIT   = 5;
  localparam int FMT_HI     = 4;
  localparam int FMT_LO     = 3;
  localparam int FPOL_BIT   = 2;
  localparam int RDYEN_BIT  = 1;
  localparam int RDYPOL_BIT = 0;
  // status field positions
  localparam int ST_SHIFT_BIT = 0;
  localparam int ST_BLOCK_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] BEGIN_RESET = 8'h00;
  localparam logic [7:0] END_RESET   = 8'h00;
  // serial clock timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SLOW_PERIOD_NS = 200;
  localparam int FAST_PERIOD_NS = 100;
  localparam int SLOW_HALF      = (SLOW_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int FAST_HALF      = (FAST_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int DIV_W          = 5;
  // data words
  localparam int WORD_BITS = 32;
  localparam int POS_W     = 5;
  localparam int MEM_AW    = 8;
  // frame formats
  localparam logic [1:0] FMT_BLOCK = 2'h0;
  localparam logic [1:0] FMT_8     = 2'h1;
  localparam logic [1:0] FMT_16    = 2'h2;
  localparam logic [1:0] FMT_32    = 2'h3;
  typedef enum logic [2:0] {
    FS_IDLE  = 3'h1,
    FS_FETCH = 3'h2,
    FS_SEND  = 3'h4
  } fetch_state_e;
endpackage

// *** sim/serial_receiver_model.sv ***
`timescale 1ns/1ps
// receiver: takes data on each rising serial clock while ready is active
module serial_receiver_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // serial pins
  input  wire logic        sclk_i,
  input  wire logic        data_i,
  input  wire logic        frame_i,
  input  wire logic        ready_i,
  // settings
  input  wire logic        fpol_i,
  input  wire logic        rpol_i,
  input  wire logic        clear_i,
  // results
  output logic [31:0]      word0_o,
  output logic [31:0]      word1_o,
  output logic [31:0]      n_words_o,
  output logic [31:0]      n_frames_o,
  output logic [31:0]      n_rises_o,
  output logic [31:0]      period_o
);
  logic        sclk_q = 1'b0;
  logic [31:0] shift  = 32'h0;
  logic [31:0] cyc    = 32'h0;
  logic [31:0] last   = 32'h0;
  logic [5:0]  bits   = 6'h00;
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    cyc    <= cyc + 32'h1;
    if (!rst_n_i || clear_i) begin
      bits       <= 6'h00;
      n_words_o  <= 32'h0;
      n_frames_o <= 32'h0;
      n_rises_o  <= 32'h0;
    end else if (sclk_i && !sclk_q) begin
      n_rises_o <= n_rises_o + 32'h1;
      period_o  <= cyc - last;
      last      <= cyc;
      if (frame_i ^ fpol_i) begin
        n_frames_o <= n_frames_o + 32'h1;
      end
      if (ready_i ^ rpol_i) begin
        shift <= {shift[30:0], data_i};
        bits  <= (bits == 6'h1F) ? 6'h00 : bits + 6'h01;
        if (bits == 6'h1F) begin
          if (n_words_o == 32'h0) word0_o <= {shift[30:0], data_i};
          else word1_o <= {shift[30:0], data_i};
          n_words_o <= n_words_o + 32'h1;
        end
      end
    end
  end
endmodule

// *** sim/tb_sync_serial_output.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_fail++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, got, exp); end end
module tb_sync_serial_output;
  import sso_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pass_start = 1'b0;
  logic        mem_rd;
  logic [7:0]  mem_addr;
  logic [31:0] mem_data = 32'h0;
  logic        drv_en = 1'b0;
  logic [3:0]  seg = 4'h0;
  logic [3:0]  pins;
  logic [7:0]  ctl = 8'h00;
  logic        clear = 1'b0;
  logic [31:0] word0, word1, n_words, n_frames, n_rises, period, r0;
  int          n_fail = 0;
  int          n_compared = 0;
  logic [15:0] radr [5] = '{CTRL_ADDR, BEGIN_ADDR, END_ADDR, STATUS_ADDR,
                            16'h2074};
  logic [7:0]  rwd [5]  = '{8'h1F, 8'h5A, 8'hA5, 8'hFF, 8'hFF};
  logic [7:0]  rexp [5] = '{8'h1F, 8'h5A, 8'hA5, 8'h00, 8'h00};
  logic [7:0]  tctl [4] = '{8'hBA, 8'h82, 8'hF3, 8'hCF};
  logic [31:0] tfr [4]  = '{32'd2, 32'd1, 32'd4, 32'd8};
  always #4 clk = ~clk;
  sync_serial_output sync_serial_output_i (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata), .pass_start_i(pass_start), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr), .mem_data_i(mem_data),
    .display_driver_enable_i(drv_en), .display_seg_i(seg),
    .segment_pin_a_o(pins[0]), .segment_pin_b_o(pins[1]),
    .segment_pin_c_o(pins[2]), .segment_pin_d_o(pins[3]));
  serial_receiver_model serial_receiver_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .sclk_i(pins[0]), .data_i(pins[1]),
    .frame_i(pins[2]), .ready_i(pins[3]), .fpol_i(ctl[FPOL_BIT]),
    .rpol_i(ctl[RDYPOL_BIT]), .clear_i(clear), .word0_o(word0),
    .word1_o(word1), .n_words_o(n_words), .n_frames_o(n_frames),
    .n_rises_o(n_rises), .period_o(period));
  function automatic logic [31:0] expect_word(input logic [7:0] a);
    return {a, ~a, a ^ 8'h3C, 8'hC3};
  endfunction
  // data memory: word valid only in the cycle after the read
  always @(posedge clk) begin
    if (mem_rd) mem_data <= expect_word(mem_addr);
    else mem_data <= ~mem_data;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 `CHK(reg_rdata, e)
    @(posedge clk);
  endtask
  task automatic start_block();
    pass_start <= 1'b1;
    @(posedge clk);
    pass_start <= 1'b0;
  endtask
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL_ADDR, CTRL_RESET);
    rd(BEGIN_ADDR, BEGIN_RESET);
    rd(END_ADDR, END_RESET);
    for (int i = 0; i < 5; i++) begin
      wr(radr[i], rwd[i]);
      rd(radr[i], rexp[i]);
    end
    seg <= 4'hA;
    repeat (3) @(posedge clk);
    #1 `CHK(pins, 4'hA)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      clear <= 1'b1;
      ctl   <= tctl[i];
      wr(BEGIN_ADDR, 8'h03);
      wr(END_ADDR, 8'h04);
      wr(CTRL_ADDR, tctl[i]);
      clear <= 1'b0;
      start_block();
      for (int w = 0; w < 4000 && n_words < 2; w++) @(posedge clk);
      repeat (60) @(posedge clk);
      #1 `CHK(word0, expect_word(8'h03))
      `CHK(word1, expect_word(8'h04))
      `CHK(n_words, 32'd2)
      `CHK(n_frames, tfr[i])
      `CHK(period, 32'(ctl[FAST_BIT] ? 2 * FAST_HALF : 2 * SLOW_HALF))
      `CHK(pins[3], ctl[RDYPOL_BIT])
      `CHK(pins[2], ctl[FPOL_BIT])
      rd(STATUS_ADDR, 8'h00);
      r0 = n_rises;
      repeat (100) @(posedge clk);
      #1 `CHK(n_rises != r0, !ctl[GATE_BIT])
      $display("test transfer %0d done", i);
    end
    drv_en <= 1'b1;
    seg    <= 4'h5;
    wr(CTRL_ADDR, 8'h80);
    start_block();
    repeat (50) @(posedge clk);
    #1 `CHK(pins, 4'h5)
    rd(STATUS_ADDR, 8'h00);
    drv_en <= 1'b0;
    r0 = n_rises;
    repeat (100) @(posedge clk);
    #1 `CHK(n_rises != r0, 1'b1)
    $display("test display driver done");
    seg <= 4'hA;
    wr(CTRL_ADDR, 8'hA0);
    start_block();
    repeat (200) @(posedge clk);
    #1 `CHK(pins[3], 1'b1)
    rd(STATUS_ADDR, 8'h03);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(pins, 4'h0)
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL_ADDR, CTRL_RESET);
    $display("test ready off and reset done");
    summarize();
  end
endmodule
